// File: hw/lpm_low_power_mode_select.sv
`timescale 1ns/1ps
module lpm_low_power_mode_select #(
   parameter int P_WAIT_BASE = lpm_pkg::WAIT_BASE_STATES
) (
   input  wire logic        i_mclk,
   input  wire logic        i_rst_b,
   input  wire logic [3:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic [31:0]      o_avs_readdata,
   output logic             o_avs_waitrequest,
   input  wire logic        i_sleep_exec,
   input  wire logic        i_standby_select,
   input  wire logic        i_watch_timer_on,
   input  wire logic        i_wake,
   input  wire logic        i_external_subclock_pin,
   output logic [2:0]       o_mode,
   output logic             o_halted,
   output logic             o_medium_speed,
   output logic             o_subclk,
   output logic             o_subclk_sample
);
   logic [7:0]       low_power_control_q;
   logic [7:0]       low_power_control_d;
   logic [7:0]       standby_control_q;
   logic [7:0]       standby_control_d;
   logic             ack_q;
   logic             ack_d;
   logic [31:0]      rdata_q;
   logic [31:0]      rdata_d;
   logic             req;
   logic             wr_en;
   logic [31:0]      rd_mux;
   lpm_pkg::lpm_mode_e mode_q;
   lpm_pkg::lpm_mode_e mode_d;
   lpm_pkg::lpm_mode_e resume_q;
   lpm_pkg::lpm_mode_e resume_d;
   logic             low_speed_cap_q;
   logic             low_speed_cap_d;
   logic             stab_start;
   logic             stab_busy;
   logic             stab_done;
   logic             direct_transfer_flag;
   logic             low_speed_flag;
   logic             sysclk_high;

   // ---------------- avalon slave: one wait state per access
   assign req               = i_avs_read | i_avs_write;
   assign o_avs_waitrequest = req & ~ack_q;
   assign wr_en             = i_avs_write & ack_q;

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (i_avs_address)
         lpm_pkg::ADDR_LOW_POWER_CONTROL: begin
            rd_mux[7:0] = low_power_control_q;
         end
         lpm_pkg::ADDR_STANDBY_CONTROL: begin
            rd_mux[7:0] = standby_control_q;
         end
         lpm_pkg::ADDR_MODE_STATUS: begin
            rd_mux[lpm_pkg::STATUS_MODE_LSB +: 3] = mode_q;
            rd_mux[lpm_pkg::STATUS_MEDIUM]        = ~sysclk_high;
            rd_mux[lpm_pkg::STATUS_SUBCLK]        = o_subclk;
            rd_mux[lpm_pkg::STATUS_SUBCLK_OK]     =
               low_power_control_q[lpm_pkg::BIT_SUBCLK_ENABLE];
         end
         default: begin
            rd_mux = 32'h0000_0000;
         end
      endcase
   end

   always_comb begin
      ack_d               = req & ~ack_q;
      rdata_d             = rdata_q;
      low_power_control_d = low_power_control_q;
      standby_control_d   = standby_control_q;
      if (i_avs_read & ~ack_q) begin
         rdata_d = rd_mux;
      end
      if (wr_en & i_avs_byteenable[0]) begin
         // reserved low nibble stays zero whatever is written
         if (i_avs_address == lpm_pkg::ADDR_LOW_POWER_CONTROL) begin
            low_power_control_d = i_avs_writedata[7:0] &
                                  lpm_pkg::LOW_POWER_CONTROL_MASK;
         end
         if (i_avs_address == lpm_pkg::ADDR_STANDBY_CONTROL) begin
            standby_control_d = i_avs_writedata[7:0] & lpm_pkg::STANDBY_CONTROL_MASK;
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ack_q               <= 1'b0;
         rdata_q             <= 32'h0000_0000;
         low_power_control_q <= lpm_pkg::LOW_POWER_CONTROL_RESET;
         standby_control_q   <= lpm_pkg::STANDBY_CONTROL_RESET;
      end else begin
         ack_q               <= ack_d;
         rdata_q             <= rdata_d;
         low_power_control_q <= low_power_control_d;
         standby_control_q   <= standby_control_d;
      end
   end

   assign o_avs_readdata = rdata_q;

   // ---------------- mode selection
   // flags read live only in the sleep cycle; later writes cannot redirect
   assign direct_transfer_flag = low_power_control_q[lpm_pkg::BIT_DIRECT_TRANSFER];
   assign low_speed_flag       = low_power_control_q[lpm_pkg::BIT_LOW_SPEED];
   assign sysclk_high = (standby_control_q[lpm_pkg::SYSCLK_SELECT_LSB +: 3] ==
                         lpm_pkg::SYSCLK_HIGH_SPEED);

   always_comb begin
      mode_d     = mode_q;
      resume_d   = resume_q;
      low_speed_cap_d = low_speed_cap_q;
      stab_start = 1'b0;
      case (mode_q)
         lpm_pkg::LPM_HIGH: begin
            if (i_sleep_exec) begin
               low_speed_cap_d = low_speed_flag;
               if (!i_standby_select) begin
                  if (!low_speed_flag) begin
                     mode_d = lpm_pkg::LPM_SLEEP;
                  end
               end else if (!low_speed_flag) begin
                  // low-speed flag clear keeps to sleep, standby or watch
                  mode_d = i_watch_timer_on ? lpm_pkg::LPM_WATCH
                                            : lpm_pkg::LPM_SSTBY;
               end else if (sysclk_high) begin
                  // low-speed targets only from full speed clock
                  mode_d = direct_transfer_flag ? lpm_pkg::LPM_SUBACT
                                                : lpm_pkg::LPM_WATCH;
               end
            end
         end
         lpm_pkg::LPM_SUBACT: begin
            if (i_sleep_exec) begin
               low_speed_cap_d = low_speed_flag;
               if (!i_standby_select) begin
                  if (low_speed_flag) begin
                     mode_d = lpm_pkg::LPM_SUBSLEEP;
                  end
               end else if (!direct_transfer_flag) begin
                  mode_d = lpm_pkg::LPM_WATCH;
               end else if (!low_speed_flag) begin
                  // direct return still waits for the oscillator
                  resume_d   = lpm_pkg::LPM_HIGH;
                  mode_d     = lpm_pkg::LPM_STAB;
                  stab_start = 1'b1;
               end
            end
         end
         lpm_pkg::LPM_SLEEP: begin
            if (i_wake) begin
               mode_d = lpm_pkg::LPM_HIGH;
            end
         end
         lpm_pkg::LPM_SUBSLEEP: begin
            if (i_wake) begin
               mode_d = lpm_pkg::LPM_SUBACT;
            end
         end
         lpm_pkg::LPM_SSTBY: begin
            if (i_wake) begin
               resume_d   = lpm_pkg::LPM_HIGH;
               mode_d     = lpm_pkg::LPM_STAB;
               stab_start = 1'b1;
            end
         end
         lpm_pkg::LPM_WATCH: begin
            if (i_wake) begin
               resume_d   = low_speed_cap_q ? lpm_pkg::LPM_SUBACT
                                            : lpm_pkg::LPM_HIGH;
               mode_d     = lpm_pkg::LPM_STAB;
               stab_start = 1'b1;
            end
         end
         lpm_pkg::LPM_STAB: begin
            if (stab_done) begin
               mode_d = resume_q;
            end
         end
         default: begin
            mode_d = lpm_pkg::LPM_HIGH;
         end
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         mode_q   <= lpm_pkg::LPM_HIGH;
         resume_q <= lpm_pkg::LPM_HIGH;
         low_speed_cap_q <= 1'b0;
      end else begin
         mode_q   <= mode_d;
         resume_q <= resume_d;
         low_speed_cap_q <= low_speed_cap_d;
      end
   end

   lpm_stab_timer #(
      .P_WAIT_BASE (P_WAIT_BASE)
   ) u_stab_timer (
      .i_mclk        (i_mclk),
      .i_rst_b       (i_rst_b),
      .i_start       (stab_start),
      .i_wait_select (standby_control_q[lpm_pkg::STANDBY_WAIT_LSB +: 3]),
      .o_busy        (stab_busy),
      .o_done        (stab_done)
   );

   lpm_subclk_sampler u_subclk_sampler (
      .i_mclk        (i_mclk),
      .i_rst_b       (i_rst_b),
      .i_enable      (low_power_control_q[lpm_pkg::BIT_SUBCLK_ENABLE]),
      .i_div4_select (low_power_control_q[lpm_pkg::BIT_NOISE_SAMPLE]),
      .i_pin         (i_external_subclock_pin),
      .o_subclk      (o_subclk),
      .o_sample_en   (o_subclk_sample)
   );

   assign o_mode         = mode_q;
   assign o_halted       = (mode_q != lpm_pkg::LPM_HIGH) &&
                           (mode_q != lpm_pkg::LPM_SUBACT) && !stab_busy;
   assign o_medium_speed = (mode_q == lpm_pkg::LPM_HIGH) && !sysclk_high;
endmodule

// File: hw/lpm_pkg.sv
package lpm_pkg;
   // avalon byte addresses
   localparam logic [3:0] ADDR_LOW_POWER_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_STANDBY_CONTROL   = 4'h4;
   localparam logic [3:0] ADDR_MODE_STATUS       = 4'h8;

   // low_power_control fields
   localparam int BIT_DIRECT_TRANSFER = 7;
   localparam int BIT_LOW_SPEED       = 6;
   localparam int BIT_NOISE_SAMPLE    = 5;
   localparam int BIT_SUBCLK_ENABLE   = 4;
   localparam logic [7:0] LOW_POWER_CONTROL_RESET = 8'h00;
   localparam logic [7:0] LOW_POWER_CONTROL_MASK  = 8'hf0;

   // standby_control fields
   localparam int STANDBY_WAIT_LSB  = 4;
   localparam int SYSCLK_SELECT_LSB = 0;
   localparam logic [7:0] STANDBY_CONTROL_RESET = 8'h00;
   localparam logic [7:0] STANDBY_CONTROL_MASK  = 8'h77;
   localparam logic [2:0] SYSCLK_HIGH_SPEED     = 3'h0;

   // mode_status fields
   localparam int STATUS_MODE_LSB  = 0;
   localparam int STATUS_MEDIUM    = 3;
   localparam int STATUS_SUBCLK    = 4;
   localparam int STATUS_SUBCLK_OK = 5;

   // stabilisation wait, in states (system clock cycles)
   localparam int WAIT_BASE_STATES  = 8192;
   localparam int WAIT_SHORT_STATES = 16;
   localparam logic [2:0] WAIT_SEL_RESERVED = 3'h6;
   localparam logic [2:0] WAIT_SEL_SHORT    = 3'h7;
   localparam logic [2:0] WAIT_SEL_LONGEST  = 3'h5;
   localparam int WAIT_CNT_W = 20;

   // noise sampling dividers
   localparam int SAMPLE_DIV_SLOW = 4;
   localparam int SAMPLE_DIV_FAST = 2;
   localparam int SAMPLE_DIV_W    = 2;

   typedef enum logic [2:0] {
      LPM_HIGH     = 3'b000,
      LPM_SLEEP    = 3'b001,
      LPM_SSTBY    = 3'b010,
      LPM_WATCH    = 3'b011,
      LPM_SUBACT   = 3'b100,
      LPM_SUBSLEEP = 3'b101,
      LPM_STAB     = 3'b110
   } lpm_mode_e;
endpackage

// File: hw/lpm_stab_timer.sv
`timescale 1ns/1ps
module lpm_stab_timer #(
   parameter int P_WAIT_BASE = lpm_pkg::WAIT_BASE_STATES
) (
   input  wire logic       i_mclk,
   input  wire logic       i_rst_b,
   input  wire logic       i_start,
   input  wire logic [2:0] i_wait_select,
   output logic            o_busy,
   output logic            o_done
);
   logic [lpm_pkg::WAIT_CNT_W-1:0] cnt_q;
   logic [lpm_pkg::WAIT_CNT_W-1:0] cnt_d;
   logic [lpm_pkg::WAIT_CNT_W-1:0] load_val;
   logic                           done_q;
   logic                           done_d;

   always_comb begin
      // reserved code falls back to the longest wait, the safe side
      if (i_wait_select == lpm_pkg::WAIT_SEL_SHORT) begin
         load_val = lpm_pkg::WAIT_CNT_W'(lpm_pkg::WAIT_SHORT_STATES - 1);
      end else if (i_wait_select == lpm_pkg::WAIT_SEL_RESERVED) begin
         load_val = lpm_pkg::WAIT_CNT_W'((P_WAIT_BASE << lpm_pkg::WAIT_SEL_LONGEST) - 1);
      end else begin
         load_val = lpm_pkg::WAIT_CNT_W'((P_WAIT_BASE << i_wait_select) - 1);
      end
   end

   always_comb begin
      cnt_d  = cnt_q;
      done_d = 1'b0;
      if (i_start) begin
         cnt_d = load_val;
      end else if (cnt_q != '0) begin
         cnt_d  = cnt_q - 1'b1;
         done_d = (cnt_q == lpm_pkg::WAIT_CNT_W'(1));
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_q  <= '0;
         done_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         done_q <= done_d;
      end
   end

   assign o_busy = (cnt_q != '0);
   assign o_done = done_q;
endmodule

// File: hw/lpm_subclk_sampler.sv
`timescale 1ns/1ps
module lpm_subclk_sampler (
   input  wire logic i_mclk,
   input  wire logic i_rst_b,
   input  wire logic i_enable,
   input  wire logic i_div4_select,
   input  wire logic i_pin,
   output logic      o_subclk,
   output logic      o_sample_en
);
   logic                            sync1_q;
   logic                            sync2_q;
   logic [lpm_pkg::SAMPLE_DIV_W-1:0] div_q;
   logic [lpm_pkg::SAMPLE_DIV_W-1:0] div_d;
   logic                            last_q;
   logic                            last_d;
   logic                            out_q;
   logic                            out_d;
   logic                            tick;

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else begin
         sync1_q <= i_pin;
         sync2_q <= sync1_q;
      end
   end

   always_comb begin
      tick = 1'b0;
      if (i_div4_select) begin
         tick = (div_q == lpm_pkg::SAMPLE_DIV_W'(lpm_pkg::SAMPLE_DIV_SLOW - 1));
      end else begin
         tick = (div_q >= lpm_pkg::SAMPLE_DIV_W'(lpm_pkg::SAMPLE_DIV_FAST - 1));
      end
      div_d  = tick ? '0 : div_q + 1'b1;
      last_d = last_q;
      out_d  = out_q;
      if (!i_enable) begin
         // pin ignored entirely while disabled
         div_d  = '0;
         last_d = 1'b0;
         out_d  = 1'b0;
      end else if (tick) begin
         last_d = sync2_q;
         // a level must hold over two samples to pass
         if (sync2_q == last_q) begin
            out_d = sync2_q;
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         div_q  <= '0;
         last_q <= 1'b0;
         out_q  <= 1'b0;
      end else begin
         div_q  <= div_d;
         last_q <= last_d;
         out_q  <= out_d;
      end
   end

   assign o_subclk    = out_q;
   assign o_sample_en = i_enable & tick;
endmodule

// File: test/lpm_low_power_mode_select_assertions.sv
`timescale 1ns/1ps
module lpm_mode_select_chk #(
   parameter int P_WAIT_BASE = 16
) (
   input wire logic        i_mclk,
   input wire logic        i_rst_b,
   input wire logic [3:0]  i_avs_address,
   input wire logic        i_avs_read,
   input wire logic        i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [31:0] o_avs_readdata,
   input wire logic        o_avs_waitrequest,
   input wire logic        i_sleep_exec,
   input wire logic        i_standby_select,
   input wire logic        i_watch_timer_on,
   input wire logic [2:0]  o_mode,
   input wire logic        o_subclk,
   input wire logic        o_subclk_sample
);
   logic [3:0] ctl_q;
   logic [2:0] csel_q;
   logic       cap_q;
   int         stab_q;
   int         gap_q;
   int         calm_q;
   logic       wr0, wr4, dtf, lsf, nsel, sen, hi, sub, slp, sb;

   assign wr0 = i_avs_write && !o_avs_waitrequest && i_avs_address == 4'h0;
   assign wr4 = i_avs_write && !o_avs_waitrequest && i_avs_address == 4'h4;
   assign {dtf, lsf, nsel, sen} = ctl_q;
   assign hi  = o_mode == 3'h0;
   assign sub = o_mode == 3'h4;
   assign slp = i_sleep_exec;
   assign sb  = i_standby_select;

   // software view of the flags, rebuilt from completed bus writes
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctl_q  <= 4'h0;
         csel_q <= 3'h0;
         cap_q  <= 1'b0;
         stab_q <= 0;
         gap_q  <= 0;
         calm_q <= 0;
      end else begin
         if (wr0) ctl_q <= i_avs_writedata[7:4];
         if (wr4) csel_q <= i_avs_writedata[2:0];
         if (slp && (hi || sub)) cap_q <= lsf;
         stab_q <= (o_mode == 3'h6) ? stab_q + 1 : 0;
         gap_q  <= o_subclk_sample ? 0 : gap_q + 1;
         // divider phase may jump on a write, so spacing is judged only once settled
         calm_q <= wr0 ? 0 : (calm_q < 16 ? calm_q + 1 : 16);
      end
   end

   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);

   sequence s_one_wait;
      o_avs_waitrequest ##1 !o_avs_waitrequest;
   endsequence
   sequence s_stab_exit;
      o_mode == 3'h6 ##1 o_mode != 3'h6;
   endsequence

   a_one_wait:
      assert property ($rose(i_avs_read || i_avs_write) |-> s_one_wait)
      else $error("access without exactly one wait state");
   a_ctl_readback:
      assert property (i_avs_read && !o_avs_waitrequest && i_avs_address == 4'h0
         |-> o_avs_readdata == {24'h00_0000, ctl_q, 4'h0})
      else $error("control readback wrong");
   a_high_halt:
      assert property (hi && slp && sb && !lsf
         |=> o_mode == ($past(i_watch_timer_on) ? 3'h3 : 3'h2))
      else $error("standby or watch entry wrong");
   a_high_low:
      assert property (hi && slp && sb && lsf && csel_q == 3'h0
         |=> o_mode == ($past(dtf) ? 3'h4 : 3'h3))
      else $error("low-speed entry wrong");
   a_sub_halt:
      assert property (sub && slp && sb && !(dtf && lsf)
         |=> o_mode == ($past(dtf) ? 3'h6 : 3'h3))
      else $error("subactive sleep target wrong");
   a_resume_mode:
      assert property (s_stab_exit |-> o_mode == (cap_q ? 3'h4 : 3'h0))
      else $error("resume mode wrong");
   // wait select stays at its reset value throughout the bench
   a_stab_length:
      assert property (s_stab_exit |-> stab_q == P_WAIT_BASE)
      else $error("stabilisation wait length wrong");
   a_subclk_off:
      assert property (!sen && !$past(sen) |-> !o_subclk && !o_subclk_sample)
      else $error("subclock active while disabled");
   a_sample_rate:
      assert property (o_subclk_sample && sen && calm_q == 16 |-> gap_q == (nsel ? 3 : 1))
      else $error("sampling tick spacing wrong");
endmodule

bind lpm_low_power_mode_select lpm_mode_select_chk #(.P_WAIT_BASE(P_WAIT_BASE)) i_chk (.*);

// File: test/lpm_low_power_mode_select_bench.sv
`timescale 1ns/1ps
module lpm_low_power_mode_select_bench;
   localparam int WB = 16;
   logic        clk = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0, pin = 1'b0;
   logic        slp = 1'b0, stby = 1'b0, tmr = 1'b0, wake = 1'b0;
   logic [3:0]  adr = 4'h0;
   logic [31:0] wd = 32'h0000_0000;
   logic [31:0] rdat, q;
   logic [2:0]  mode;
   logic        wreq, halted, med, sclk, smp;
   int          miscompares = 0, total_checks = 0;

   lpm_low_power_mode_select #(.P_WAIT_BASE(WB)) i_dut (
      .i_mclk(clk), .i_rst_b(rst_b), .i_avs_address(adr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
      .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_sleep_exec(slp),
      .i_standby_select(stby), .i_watch_timer_on(tmr), .i_wake(wake),
      .i_external_subclock_pin(pin), .o_mode(mode), .o_halted(halted),
      .o_medium_speed(med), .o_subclk(sclk), .o_subclk_sample(smp)
   );

   initial begin
      forever #5 clk = ~clk;
   end

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // waitrequest and read data are taken at the rising edge itself
   task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
      int n;
      @(posedge clk);
      adr <= a;
      wd  <= d;
      wr  <= w;
      rd  <= !w;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      q = rdat;
      if (n == 50) begin
         check("bus answer", 32'(wreq), 32'h0000_0000);
         summarize();
      end
      wr <= 1'b0;
      rd <= 1'b0;
      @(negedge clk);
   endtask

   task automatic pulse(logic w, logic sb, logic tm);
      @(posedge clk);
      stby <= sb;
      tmr  <= tm;
      slp  <= !w;
      wake <= w;
      @(posedge clk);
      slp  <= 1'b0;
      wake <= 1'b0;
      @(negedge clk);
   endtask

   // flips the low-speed flag while halted: the captured value must win
   task automatic step(logic [7:0] ctl, logic sb, logic tm, logic [2:0] em, logic [2:0] ea);
      int n, k;
      bus(1'b1, 4'h0, {24'h00_0000, ctl});
      pulse(1'b0, sb, tm);
      check("mode entered", 32'(mode), 32'(em));
      check("halted", 32'(halted), 32'(em inside {3'h1, 3'h2, 3'h3, 3'h5}));
      if (halted === 1'b1) begin
         bus(1'b1, 4'h0, {24'h00_0000, ctl ^ 8'h40});
         pulse(1'b1, sb, tm);
      end
      n = 0;
      for (k = 0; k < 300 && mode !== ea; k++) begin
         n += (mode === 3'h6);
         @(negedge clk);
      end
      check("mode resumed", 32'(mode), 32'(ea));
      check("wait states", n, (em inside {3'h2, 3'h3, 3'h6}) ? WB : 0);
      if (k == 300) summarize();
   endtask

   task automatic t_regs();
      bus(1'b0, 4'h0, 32'h0000_0000);
      check("control reset", q, 32'h0000_0000);
      bus(1'b1, 4'h0, 32'h0000_00ff);
      bus(1'b0, 4'h0, 32'h0000_0000);
      check("control readback", q, 32'h0000_00f0);
      bus(1'b1, 4'h8, 32'h0000_00ff);
      bus(1'b0, 4'h8, 32'h0000_0000);
      check("status", q, 32'h0000_0020);
      bus(1'b1, 4'hc, 32'h0000_00ff);
      bus(1'b0, 4'hc, 32'h0000_0000);
      check("unmapped", q, 32'h0000_0000);
      bus(1'b1, 4'h4, 32'h0000_0001);
      check("medium speed", 32'(med), 32'h0000_0001);
      step(8'h40, 1'b1, 1'b0, 3'h0, 3'h0);
      bus(1'b1, 4'h4, 32'h0000_0000);
      check("high speed", 32'(med), 32'h0000_0000);
   endtask

   task automatic t_modes();
      step(8'h00, 1'b0, 1'b0, 3'h1, 3'h0);
      step(8'h00, 1'b1, 1'b0, 3'h2, 3'h0);
      step(8'h00, 1'b1, 1'b1, 3'h3, 3'h0);
      step(8'h40, 1'b1, 1'b0, 3'h3, 3'h4);
      step(8'h40, 1'b0, 1'b0, 3'h5, 3'h4);
      step(8'h80, 1'b1, 1'b0, 3'h6, 3'h0);
      step(8'hc0, 1'b1, 1'b0, 3'h4, 3'h4);
      step(8'h00, 1'b1, 1'b0, 3'h3, 3'h0);
   endtask

   task automatic t_subclk();
      logic [7:0] cfg[3] = '{8'h30, 8'h10, 8'h00};
      int         ticks[3] = '{10, 20, 0};
      int         n;
      for (int c = 0; c < 3; c++) begin
         bus(1'b1, 4'h0, {24'h00_0000, cfg[c]});
         n = 0;
         for (int k = 0; k < 40; k++) begin
            @(posedge clk);
            pin <= k[4];
            @(negedge clk);
            n += (smp === 1'b1);
            if (k == 31) check("subclock level", 32'(sclk), 32'(c < 2));
         end
         check("sample ticks", n, ticks[c]);
      end
   endtask

   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      t_regs();
      t_modes();
      t_subclk();
      summarize();
   end
endmodule
